// [hdl/rhs_pkg.sv]
// Shared constants, types and helpers for the humidity sensor command port
// How it works
// - Target answers at seven-bit address 0x40
// - 0xE5 hold, 0xF5 poll humidity conversion
// - 0xE3 hold, 0xF3 poll temperature conversion
// - 0xE0 returns temperature from last humidity
// - 0xE6/0xE7 user register, 0x51/0x11 heater
// - 0xFA 0x0F, 0xFC 0xC9 read identification
// - Host sends only listed command codes
// - Busy conversion: stretch or refuse read
// - Poll mode NACKs address; host retries
// - Checksum only after host ACKs LSB
// - CRC-8 poly 0x31, start 0x00
// - Checksum for measurements and ID only
// - Humidity conversion also keeps temperature
// - Results are 16 bits, MSB first
// - Humidity LSB ends in binary 10
// - Temperature LSB ends in binary 00
// - Previous temperature: MSB ACK, LSB NACK, STOP
// - Register read: one byte, NACK, STOP
// - Register write: command, data, each ACKed
// - STOP before repeated start is accepted
// - User register bit 2 switches heater
package rhs_pkg;
	localparam logic [6:0] DEV_ADDR     = 7'h40;
	localparam logic [7:0] CMD_HUM_HOLD = 8'hE5;
	localparam logic [7:0] CMD_HUM_POLL = 8'hF5;
	localparam logic [7:0] CMD_TMP_HOLD = 8'hE3;
	localparam logic [7:0] CMD_TMP_POLL = 8'hF3;
	localparam logic [7:0] CMD_PREV_TMP = 8'hE0;
	localparam logic [7:0] CMD_RESET    = 8'hFE;
	localparam logic [7:0] CMD_WR_USER  = 8'hE6;
	localparam logic [7:0] CMD_RD_USER  = 8'hE7;
	localparam logic [7:0] CMD_WR_HTR   = 8'h51;
	localparam logic [7:0] CMD_RD_HTR   = 8'h11;
	localparam logic [7:0] CMD_ID1_A    = 8'hFA;
	localparam logic [7:0] CMD_ID1_B    = 8'h0F;
	localparam logic [7:0] CMD_ID2_A    = 8'hFC;
	localparam logic [7:0] CMD_ID2_B    = 8'hC9;
	// Register reset values and writable masks
	localparam logic [7:0] USER_RST     = 8'h3A;
	localparam logic [7:0] USER_WMASK   = 8'hBF;
	localparam logic [7:0] HTR_RST      = 8'h00;
	localparam logic [7:0] HTR_WMASK    = 8'h0F;
	localparam int         HTR_ON_BIT   = 2;
	// Result tails and checksum
	localparam logic [1:0] HUM_TAIL     = 2'h2;
	localparam logic [1:0] TMP_TAIL     = 2'h0;
	localparam logic [7:0] CRC_POLY     = 8'h31;
	localparam logic [7:0] CRC_INIT     = 8'h00;
	// Bit counting: eight data bits then the acknowledge slot
	localparam logic [3:0] BIT_ACK      = 4'h8;
	// Timing
	localparam int         CORE_NS      = 5;
	localparam int         CONV_NS      = 20000;
	localparam int         CONV_CYC     = (CONV_NS + CORE_NS - 1) / CORE_NS;
	localparam int         SCL_NS       = 1250;
	localparam int         QTR_CYC      = SCL_NS / 4 / CORE_NS;

	// Device link states
	typedef enum logic [2:0] {L_IDLE, L_RX, L_RACK, L_TX, L_TACK, L_HOLD} rhs_lnk_e;
	// Host bit engine states and transfer phases
	typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} rhs_hst_e;
	typedef enum logic [2:0] {P_ADDRW, P_CMD, P_ARG, P_ADDRR, P_READ} rhs_ph_e;

	// One byte through the CRC-8, most significant bit first
	function automatic logic [7:0] rhs_crc8(input logic [7:0] crc, input logic [7:0] d);
		logic [7:0] c;
		c = crc ^ d;
		for (int k = 0; k < 8; k++) begin
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction : rhs_crc8
endpackage : rhs_pkg

// [hdl/rhs_if.sv]
// Two-wire link between host and sensor, with open-drain resolution
`timescale 1ns/100ps
interface rhs_if;
	logic dev_scl_oe;
	logic dev_sda_oe;
	logic dev_scl_o;
	logic dev_sda_o;
	logic host_scl_oe;
	logic host_sda_oe;
	logic host_scl_o;
	logic host_sda_o;
	logic scl;
	logic sda;

	// Wired-AND with pull-ups
	assign scl = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o));
	assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));

	modport dev (output dev_scl_oe, dev_sda_oe, dev_scl_o, dev_sda_o, input scl, sda);
	modport host (output host_scl_oe, host_sda_oe, host_scl_o, host_sda_o, input scl, sda);
endinterface : rhs_if

// [hdl/rhs_dev.sv]
// Sensor end: command decoder, conversion sequencer and result sender
`timescale 1ns/100ps
module rhs_dev import rhs_pkg::*; #(
	parameter logic [31:0] SER_A = 32'h1122_3344, // Arbitrary value
	parameter logic [31:0] SER_B = 32'h5566_7788  // Arbitrary value
) (
	// Clocks and reset
	input  wire logic        core_clk_i,
	input  wire logic        link_clk_i,
	input  wire logic        rst_i,
	// Sensor samples
	input  wire logic [15:0] hum_sample_i,
	input  wire logic [15:0] temp_sample_i,
	// Heater and status
	output logic             heater_on_o,
	output logic [3:0]       heater_level_o,
	output logic             busy_o,
	// Link pins
	rhs_if.dev               bus
);
	// Link domain
	logic       lrst_m_ff, lrst_ff;
	logic       scl_m_ff, scl_s_ff, scl_p_ff;
	logic       sda_m_ff, sda_s_ff, sda_p_ff;
	rhs_lnk_e   st_ff;
	logic [3:0] bit_ff;
	logic [7:0] sh_ff;
	logic       addr_ph_ff, rd_ff, ack_ff, hack_ff, last_ff;
	logic [1:0] widx_ff;
	logic [7:0] cmd_ff, cmd2_ff, crc_ff, user_ff, htr_ff;
	logic [2:0] tidx_ff;
	logic       pend_ff, hold_ff, kind_ff, start_tgl_ff;
	logic       done_m_ff, done_s_ff, done_p_ff;
	logic       sda_oe_ff, scl_oe_ff;
	// Core domain
	logic        st_m_ff, st_s_ff, st_p_ff, kind_m_ff, kind_s_ff;
	logic        run_ff, done_tgl_ff;
	logic [11:0] cnt_ff;
	logic [15:0] hum_res_ff, tmp_res_ff, prev_ff;
	logic [4:0]  htr_m_ff, htr_s_ff;

	logic       scl_rise, scl_fall, bus_start, bus_stop, addr_hit;
	logic [9:0] nxt_pick;

	// Picks the byte at position i of the answer: {checksum, last, data}
	function automatic logic [9:0] tx_pick(input logic [2:0] i);
		logic [15:0] w;
		logic [1:0]  j;
		w = 16'h0000;
		j = 2'h0;
		tx_pick = {2'h1, 8'hFF};
		if (cmd_ff == CMD_HUM_HOLD || cmd_ff == CMD_HUM_POLL ||
		    cmd_ff == CMD_TMP_HOLD || cmd_ff == CMD_TMP_POLL) begin
			w = (cmd_ff == CMD_HUM_HOLD || cmd_ff == CMD_HUM_POLL) ?
			    {hum_res_ff[15:2], HUM_TAIL} : {tmp_res_ff[15:2], TMP_TAIL};
			if (i == 3'h0)
				tx_pick = {2'h0, w[15:8]};
			else if (i == 3'h1)
				tx_pick = {2'h0, w[7:0]};
			else
				tx_pick = {2'h3, crc_ff};
		end else if (cmd_ff == CMD_PREV_TMP) begin
			// kept temperature also ends in the temperature tail
			tx_pick = (i == 3'h0) ? {2'h0, prev_ff[15:8]} : {2'h1, prev_ff[7:2], TMP_TAIL};
		end else if (cmd_ff == CMD_RD_USER) begin
			tx_pick = {2'h1, user_ff};
		end else if (cmd_ff == CMD_RD_HTR) begin
			tx_pick = {2'h1, htr_ff};
		end else if (cmd_ff == CMD_ID1_A && cmd2_ff == CMD_ID1_B) begin
			// first half, checksum after each byte
			if (i[0])
				tx_pick = {1'b1, i == 3'h7, crc_ff};
			else
				tx_pick = {2'h0, SER_A[8 * (3 - i[2:1]) +: 8]};
		end else if (cmd_ff == CMD_ID2_A && cmd2_ff == CMD_ID2_B) begin
			// second half, checksum after each pair
			j = (i < 3'h2) ? i[1:0] : 2'(i - 3'h1);
			if (i == 3'h2 || i == 3'h5)
				tx_pick = {1'b1, i == 3'h5, crc_ff};
			else
				tx_pick = {2'h0, SER_B[8 * (3 - j) +: 8]};
		end
	endfunction : tx_pick

	// Reset and pin synchronisers on the link clock
	always_ff @(posedge link_clk_i) begin
		lrst_m_ff <= rst_i;
		lrst_ff   <= lrst_m_ff;
		scl_m_ff  <= bus.scl;
		scl_s_ff  <= scl_m_ff;
		scl_p_ff  <= scl_s_ff;
		sda_m_ff  <= bus.sda;
		sda_s_ff  <= sda_m_ff;
		sda_p_ff  <= sda_s_ff;
		done_m_ff <= done_tgl_ff;
		done_s_ff <= done_m_ff;
		done_p_ff <= done_s_ff;
	end

	// Line events
	assign scl_rise  = scl_s_ff & ~scl_p_ff;
	assign scl_fall  = ~scl_s_ff & scl_p_ff;
	assign bus_start = scl_s_ff & scl_p_ff & sda_p_ff & ~sda_s_ff;
	assign bus_stop  = scl_s_ff & scl_p_ff & ~sda_p_ff & sda_s_ff;
	assign addr_hit  = (sh_ff[7:1] == DEV_ADDR);
	// Next answer byte; a process so command and result changes re-evaluate it
	always_comb nxt_pick = tx_pick(tidx_ff);

	// Protocol engine, command decode and registers
	always_ff @(posedge link_clk_i) begin
		if (lrst_ff) begin
			st_ff <= L_IDLE;
			bit_ff <= 4'h0;
			sh_ff <= 8'h00;
			{addr_ph_ff, rd_ff, ack_ff, hack_ff, last_ff} <= 5'h00;
			widx_ff <= 2'h0;
			cmd_ff <= 8'h00;
			cmd2_ff <= 8'h00;
			crc_ff <= CRC_INIT;
			tidx_ff <= 3'h0;
			user_ff <= USER_RST;
			htr_ff <= HTR_RST;
			{pend_ff, hold_ff, kind_ff, start_tgl_ff} <= 4'h0;
			sda_oe_ff <= 1'b0;
			scl_oe_ff <= 1'b0;
		end else begin
			// Conversion finished
			if (done_s_ff != done_p_ff)
				pend_ff <= 1'b0;
			if (bus_start) begin
				st_ff <= L_RX;
				bit_ff <= 4'h0;
				addr_ph_ff <= 1'b1;
				sda_oe_ff <= 1'b0;
			end else if (bus_stop) begin
				st_ff <= L_IDLE;
				sda_oe_ff <= 1'b0;
				scl_oe_ff <= 1'b0;
			end else begin
				case (st_ff)
					L_RX: begin
						if (scl_rise) begin
							sh_ff <= {sh_ff[6:0], sda_s_ff};
							bit_ff <= bit_ff + 4'h1;
						end else if (scl_fall && bit_ff == BIT_ACK) begin
							st_ff <= L_RACK;
							addr_ph_ff <= 1'b0;
							ack_ff <= 1'b1;
							sda_oe_ff <= 1'b1;
							if (addr_ph_ff) begin
								rd_ff <= sh_ff[0];
								widx_ff <= 2'h0;
								tidx_ff <= 3'h0;
								crc_ff <= CRC_INIT;
								if (!addr_hit || (sh_ff[0] && pend_ff && !hold_ff)) begin
									ack_ff <= 1'b0;
									sda_oe_ff <= 1'b0;
								end
							end else begin
								widx_ff <= widx_ff + 2'h1;
								if (widx_ff == 2'h0) begin
									cmd_ff <= sh_ff;
									if (sh_ff == CMD_HUM_HOLD || sh_ff == CMD_HUM_POLL ||
									    sh_ff == CMD_TMP_HOLD || sh_ff == CMD_TMP_POLL) begin
										pend_ff <= 1'b1;
										hold_ff <= (sh_ff == CMD_HUM_HOLD || sh_ff == CMD_TMP_HOLD);
										kind_ff <= (sh_ff == CMD_HUM_HOLD || sh_ff == CMD_HUM_POLL);
										start_tgl_ff <= ~start_tgl_ff;
									end
									if (sh_ff == CMD_RESET) begin
										user_ff <= USER_RST;
										htr_ff <= HTR_RST;
										pend_ff <= 1'b0;
										hold_ff <= 1'b0;
									end
								end else if (widx_ff == 2'h1) begin
									cmd2_ff <= sh_ff;
									if (cmd_ff == CMD_WR_USER)
										user_ff <= (user_ff & ~USER_WMASK) | (sh_ff & USER_WMASK);
									if (cmd_ff == CMD_WR_HTR)
										htr_ff <= (htr_ff & ~HTR_WMASK) | (sh_ff & HTR_WMASK);
								end
							end
						end
					end
					L_RACK: begin
						if (scl_fall) begin
							sda_oe_ff <= 1'b0;
							bit_ff <= 4'h0;
							if (!ack_ff) begin
								st_ff <= L_IDLE;
							end else if (!rd_ff) begin
								st_ff <= L_RX;
							end else if (pend_ff) begin
								st_ff <= L_HOLD;
								scl_oe_ff <= 1'b1;
							end else begin
								st_ff <= L_TX;
								sh_ff <= nxt_pick[7:0];
								sda_oe_ff <= ~nxt_pick[7];
								last_ff <= nxt_pick[8];
								tidx_ff <= tidx_ff + 3'h1;
								bit_ff <= 4'h1;
								if (!nxt_pick[9])
									crc_ff <= rhs_crc8(crc_ff, nxt_pick[7:0]);
							end
						end
					end
					L_HOLD: begin
						// SCL stays held one more cycle so SDA settles first
						if (!pend_ff) begin
							st_ff <= L_TX;
							sh_ff <= nxt_pick[7:0];
							sda_oe_ff <= ~nxt_pick[7];
							last_ff <= nxt_pick[8];
							tidx_ff <= tidx_ff + 3'h1;
							bit_ff <= 4'h1;
							crc_ff <= rhs_crc8(crc_ff, nxt_pick[7:0]);
						end
					end
					L_TX: begin
						// release a held SCL once the first bit stands on SDA
						if (scl_oe_ff)
							scl_oe_ff <= 1'b0;
						if (scl_fall) begin
							if (bit_ff == BIT_ACK) begin
								st_ff <= L_TACK;
								sda_oe_ff <= 1'b0;
							end else begin
								sda_oe_ff <= ~sh_ff[6];
								sh_ff <= {sh_ff[6:0], 1'b0};
								bit_ff <= bit_ff + 4'h1;
							end
						end
					end
					L_TACK: begin
						if (scl_rise)
							hack_ff <= ~sda_s_ff;
						if (scl_fall) begin
							// next byte only after host ACK
							if (hack_ff && !last_ff) begin
								st_ff <= L_TX;
								sh_ff <= nxt_pick[7:0];
								sda_oe_ff <= ~nxt_pick[7];
								last_ff <= nxt_pick[8];
								tidx_ff <= tidx_ff + 3'h1;
								bit_ff <= 4'h1;
								if (!nxt_pick[9])
									crc_ff <= rhs_crc8(crc_ff, nxt_pick[7:0]);
							end else begin
								st_ff <= L_IDLE;
							end
						end
					end
					default: begin
						st_ff <= L_IDLE;
					end
				endcase
			end
		end
	end

	// Start request and register levels into the core domain
	always_ff @(posedge core_clk_i) begin
		st_m_ff   <= start_tgl_ff;
		st_s_ff   <= st_m_ff;
		st_p_ff   <= st_s_ff;
		kind_m_ff <= kind_ff;
		kind_s_ff <= kind_m_ff;
		htr_m_ff  <= {user_ff[HTR_ON_BIT], htr_ff[3:0]};
		htr_s_ff  <= htr_m_ff;
	end

	// Conversion timer and result capture
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			run_ff <= 1'b0;
			cnt_ff <= 12'h000;
			done_tgl_ff <= 1'b0;
			hum_res_ff <= 16'h0000;
			tmp_res_ff <= 16'h0000;
			prev_ff <= 16'h0000;
		end else if (st_s_ff != st_p_ff) begin
			run_ff <= 1'b1;
			cnt_ff <= 12'(CONV_CYC - 1);
		end else if (run_ff) begin
			if (cnt_ff == 12'h000) begin
				run_ff <= 1'b0;
				done_tgl_ff <= ~done_tgl_ff;
				if (kind_s_ff) begin
					hum_res_ff <= hum_sample_i;
					prev_ff <= temp_sample_i;
				end else begin
					tmp_res_ff <= temp_sample_i;
				end
			end else begin
				cnt_ff <= cnt_ff - 12'h001;
			end
		end
	end

	// Outputs
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			heater_on_o <= 1'b0;
			heater_level_o <= 4'h0;
			busy_o <= 1'b0;
		end else begin
			heater_on_o <= htr_s_ff[4];
			heater_level_o <= htr_s_ff[3:0];
			busy_o <= run_ff;
		end
	end

	assign bus.dev_scl_oe = scl_oe_ff;
	assign bus.dev_sda_oe = sda_oe_ff;
	assign bus.dev_scl_o  = 1'b0; // Open drain only pulls low
	assign bus.dev_sda_o  = 1'b0;
endmodule : rhs_dev

// [hdl/rhs_host.sv]
// Host end: bus master that issues commands and reads answers
`timescale 1ns/100ps
module rhs_host import rhs_pkg::*; (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	// Request
	input  wire logic       req_i,
	input  wire logic [7:0] req_cmd_i,
	input  wire logic       req_arg_en_i,
	input  wire logic [7:0] req_arg_i,
	input  wire logic [3:0] req_rd_len_i,
	// Answer
	output logic            busy_o,
	output logic [7:0]      rd_data_o,
	output logic            rd_valid_o,
	output logic            done_o,
	output logic            nack_o,
	// Link pins
	rhs_if.host             bus
);
	logic       scl_m_ff, scl_s_ff, sda_m_ff, sda_s_ff;
	logic [7:0] div_ff;
	rhs_hst_e   st_ff;
	rhs_ph_e    ph_ff;
	logic [1:0] q_ff;
	logic [3:0] bit_ff, left_ff;
	logic [7:0] tx_ff, rx_ff, cmd_ff, arg_ff;
	logic       arg_en_ff, ackd_ff, scl_oe_ff, sda_oe_ff;
	logic       tick, adv;

	// Pin synchronisers
	always_ff @(posedge core_clk_i) begin
		scl_m_ff <= bus.scl;
		scl_s_ff <= scl_m_ff;
		sda_m_ff <= bus.sda;
		sda_s_ff <= sda_m_ff;
	end

	// Quarter-period divider for the link clock
	always_ff @(posedge core_clk_i) begin
		if (rst_i || tick)
			div_ff <= 8'h00;
		else
			div_ff <= div_ff + 8'h01;
	end
	assign tick = (div_ff == 8'(QTR_CYC - 1));
	// Quarter two waits until the line is really high
	assign adv  = tick && (q_ff != 2'h2 || scl_s_ff);

	// Transfer sequencer
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_ff <= H_IDLE;
			ph_ff <= P_ADDRW;
			q_ff <= 2'h0;
			bit_ff <= 4'h0;
			left_ff <= 4'h0;
			{tx_ff, rx_ff, cmd_ff, arg_ff} <= 32'h0000_0000;
			{arg_en_ff, ackd_ff, scl_oe_ff, sda_oe_ff} <= 4'h0;
			{busy_o, rd_valid_o, done_o, nack_o} <= 4'h0;
			rd_data_o <= 8'h00;
		end else begin
			rd_valid_o <= 1'b0;
			done_o <= 1'b0;
			if (adv && st_ff != H_IDLE)
				q_ff <= q_ff + 2'h1;
			case (st_ff)
				H_IDLE: begin
					q_ff <= 2'h0;
					if (req_i) begin
						st_ff <= H_START;
						ph_ff <= P_ADDRW;
						tx_ff <= {DEV_ADDR, 1'b0};
						cmd_ff <= req_cmd_i;
						arg_ff <= req_arg_i;
						arg_en_ff <= req_arg_en_i;
						left_ff <= req_rd_len_i;
						busy_o <= 1'b1;
						nack_o <= 1'b0;
					end
				end
				H_START: begin
					if (adv) begin
						case (q_ff)
							2'h0: sda_oe_ff <= 1'b0;
							2'h1: scl_oe_ff <= 1'b0;
							2'h2: sda_oe_ff <= 1'b1;
							default: begin
								scl_oe_ff <= 1'b1;
								bit_ff <= 4'h0;
								st_ff <= H_BYTE;
							end
						endcase
					end
				end
				H_BYTE: begin
					if (adv) begin
						case (q_ff)
							2'h0: begin
								// ACK all but the last read byte
								if (bit_ff == BIT_ACK)
									sda_oe_ff <= (ph_ff == P_READ) && (left_ff != 4'h1);
								else
									sda_oe_ff <= (ph_ff != P_READ) && !tx_ff[7];
							end
							2'h1: scl_oe_ff <= 1'b0;
							2'h2: begin
								if (bit_ff == BIT_ACK)
									ackd_ff <= ~sda_s_ff;
								else
									rx_ff <= {rx_ff[6:0], sda_s_ff};
							end
							default: begin
								scl_oe_ff <= 1'b1;
								tx_ff <= {tx_ff[6:0], 1'b0};
								bit_ff <= bit_ff + 4'h1;
								if (bit_ff == BIT_ACK) begin
									bit_ff <= 4'h0;
									case (ph_ff)
										P_ADDRW: begin
											ph_ff <= P_CMD;
											tx_ff <= cmd_ff;
											if (!ackd_ff) begin
												nack_o <= 1'b1;
												st_ff <= H_STOP;
											end
										end
										P_CMD, P_ARG: begin
											tx_ff <= {DEV_ADDR, 1'b1};
											if (ph_ff == P_CMD && arg_en_ff) begin
												ph_ff <= P_ARG;
												tx_ff <= arg_ff;
											end else if (left_ff != 4'h0) begin
												ph_ff <= P_ADDRR;
												st_ff <= H_START;
											end else begin
												st_ff <= H_STOP;
											end
										end
										P_ADDRR: begin
											tx_ff <= {DEV_ADDR, 1'b1};
											if (ackd_ff)
												ph_ff <= P_READ;
											else
												st_ff <= H_START;
										end
										default: begin
											rd_data_o <= rx_ff;
											rd_valid_o <= 1'b1;
											left_ff <= left_ff - 4'h1;
											if (left_ff == 4'h1)
												st_ff <= H_STOP;
										end
									endcase
								end
							end
						endcase
					end
				end
				default: begin
					if (adv) begin
						case (q_ff)
							2'h0: sda_oe_ff <= 1'b1;
							2'h1: scl_oe_ff <= 1'b0;
							2'h2: sda_oe_ff <= 1'b0;
							default: begin
								st_ff <= H_IDLE;
								busy_o <= 1'b0;
								done_o <= 1'b1;
							end
						endcase
					end
				end
			endcase
		end
	end

	assign bus.host_scl_oe = scl_oe_ff;
	assign bus.host_sda_oe = sda_oe_ff;
	assign bus.host_scl_o  = 1'b0;
	assign bus.host_sda_o  = 1'b0;
endmodule : rhs_host

// [sim/rhs_checker.sv]
// Link-level assertions for the sensor command port two-wire bus
`timescale 1ns/100ps
module rhs_checker (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	// Device pins
	input  wire logic dev_scl_oe,
	input  wire logic dev_sda_oe,
	input  wire logic dev_scl_o,
	input  wire logic dev_sda_o,
	// Host pins
	input  wire logic host_scl_oe,
	input  wire logic host_sda_oe,
	input  wire logic host_scl_o,
	input  wire logic host_sda_o,
	// Resolved lines
	input  wire logic scl,
	input  wire logic sda
);
	localparam int STRETCH_MAX = 4400; // Conversion time plus sync margin
	logic [15:0]   stretch_cnt_ff;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	// Length of the current device clock stretch
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			stretch_cnt_ff <= 16'h0000;
		end else begin
			stretch_cnt_ff <= dev_scl_oe ? stretch_cnt_ff + 16'h0001 : 16'h0000;
		end
	end

	a_open_drain: assert property (!dev_scl_o && !dev_sda_o && !host_scl_o && !host_sda_o)
		else $error("A link pin is driven high");
	a_dev_data_moves: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("Device changed SDA while SCL high");
	a_dev_bit_held: assert property ($rose(dev_sda_oe) |-> !scl ##[1:300] (scl && dev_sda_oe))
		else $error("Device low bit not held into SCL high");
	a_host_edge_free: assert property ($changed(host_sda_oe) && scl |-> !dev_sda_oe)
		else $error("Device drives SDA during start or stop");
	a_stop_frees: assert property ($rose(sda) && scl |-> !dev_sda_oe && !dev_scl_oe)
		else $error("Device still driving at stop");
	a_scl_fall_host: assert property ($fell(scl) |-> host_scl_oe)
		else $error("SCL fell without the host pulling it");
	a_stretch_bound: assert property (stretch_cnt_ff <= STRETCH_MAX)
		else $error("Clock stretch longer than a conversion");
	a_reset_quiet: assert property ($past(rst_i) |-> !dev_sda_oe && !dev_scl_oe && !host_scl_oe)
		else $error("Link driven right after reset");
endmodule : rhs_checker

// [sim/rh_temp_sensor_i2c_command_port_tb.sv]
// Self-checking bench: host and sensor ends joined over the two-wire link
`timescale 1ns/100ps
module rh_temp_sensor_i2c_command_port_tb import rhs_pkg::*;;
	typedef struct {
		logic [7:0] cmd;
		logic       arg_en;
		logic [7:0] arg;
		logic [3:0] len;
		logic [7:0] d [3];
		logic       hon;
		logic [3:0] lvl;
	} rhs_row_s;
	localparam logic [15:0] HUM = 16'hABCD;
	localparam logic [15:0] TMP = 16'h1237;
	logic        core_clk_i, link_clk_i, rst_i, req_i, req_arg_en_i;
	logic [7:0]  req_cmd_i, req_arg_i, rd_data_o;
	logic [3:0]  req_rd_len_i, heater_level_o;
	logic        heater_on_o, dev_busy, busy_o, rd_valid_o, done_o, nack_o;
	int          n_errors = 0;
	int          checks_done = 0;
	int          cyc = 0;
	rhs_row_s    rows [8];

	rhs_if rhs_if_i ();
	rhs_dev rhs_dev_i (.core_clk_i(core_clk_i), .link_clk_i(link_clk_i), .rst_i(rst_i),
		.hum_sample_i(HUM), .temp_sample_i(TMP), .heater_on_o(heater_on_o),
		.heater_level_o(heater_level_o), .busy_o(dev_busy), .bus(rhs_if_i));
	rhs_host rhs_host_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req_i),
		.req_cmd_i(req_cmd_i), .req_arg_en_i(req_arg_en_i), .req_arg_i(req_arg_i),
		.req_rd_len_i(req_rd_len_i), .busy_o(busy_o), .rd_data_o(rd_data_o),
		.rd_valid_o(rd_valid_o), .done_o(done_o), .nack_o(nack_o), .bus(rhs_if_i));
	rhs_checker rhs_checker_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.dev_scl_oe(rhs_if_i.dev_scl_oe), .dev_sda_oe(rhs_if_i.dev_sda_oe),
		.dev_scl_o(rhs_if_i.dev_scl_o), .dev_sda_o(rhs_if_i.dev_sda_o),
		.host_scl_oe(rhs_if_i.host_scl_oe), .host_sda_oe(rhs_if_i.host_sda_oe),
		.host_scl_o(rhs_if_i.host_scl_o), .host_sda_o(rhs_if_i.host_sda_o),
		.scl(rhs_if_i.scl), .sda(rhs_if_i.sda));

	// Core clock at 200 MHz and an unrelated 32 ns link clock
	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	initial begin
		link_clk_i = 1'b0;
		#7.3;
		forever #16 link_clk_i = ~link_clk_i;
	end

	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Bench copy of the checksum, most significant bit first
	function automatic logic [7:0] tb_crc(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		repeat (8) r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
		return r;
	endfunction : tb_crc

	// Verdict and end of run
	task complete_run;
		$display("checks %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run

	// One host transfer from a table row, comparing every byte read
	task automatic xfer(input int r);
		int nb;
		int t;
		nb = 0;
		t = 0;
		req_cmd_i = rows[r].cmd;
		req_arg_en_i = rows[r].arg_en;
		req_arg_i = rows[r].arg;
		req_rd_len_i = rows[r].len;
		req_i = 1'b1;
		@(posedge core_clk_i) #1;
		req_i = 1'b0;
		do begin
			@(posedge core_clk_i) #1;
			t++;
			if (rd_valid_o === 1'b1) begin
				if (nb < 3) chk(rd_data_o, rows[r].d[nb]);
				nb++;
			end
		end while (done_o !== 1'b1 && t < 40000);
		chk(done_o, 1'b1);
		chk(nb, rows[r].len);
		chk(nack_o, 1'b0);
		chk(heater_on_o, rows[r].hon);
		chk(heater_level_o, rows[r].lvl);
		$display("test %0d done", r);
	endtask : xfer

	// Cycle ceiling against a hung link
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 95000) begin
			n_errors++;
			complete_run();
		end
	end

	// Table rows, then the reset case
	initial begin
		rst_i = 1'b1;
		req_i = 1'b0;
		req_cmd_i = 8'h00;
		req_arg_en_i = 1'b0;
		req_arg_i = 8'h00;
		req_rd_len_i = 4'h0;
		// rows use only listed command codes
		rows[0] = '{CMD_WR_USER, 1'b1, 8'h04, 4'h0, '{8'h00, 8'h00, 8'h00}, 1'b1, 4'h0};
		rows[1] = '{CMD_RESET, 1'b0, 8'h00, 4'h0, '{8'h00, 8'h00, 8'h00},
			USER_RST[HTR_ON_BIT], HTR_RST[3:0]};
		rows[2] = rows[0];
		rows[3] = '{CMD_WR_HTR, 1'b1, 8'h05, 4'h0, '{8'h00, 8'h00, 8'h00}, 1'b1, 4'h5};
		rows[4] = '{CMD_HUM_HOLD, 1'b0, 8'h00, 4'h3,
			'{HUM[15:8], {HUM[7:2], HUM_TAIL}, 8'h00}, 1'b1, 4'h5};
		rows[4].d[2] = tb_crc(tb_crc(CRC_INIT, HUM[15:8]), {HUM[7:2], HUM_TAIL});
		rows[5] = '{CMD_PREV_TMP, 1'b0, 8'h00, 4'h2,
			'{TMP[15:8], {TMP[7:2], TMP_TAIL}, 8'h00}, 1'b1, 4'h5};
		rows[6] = '{CMD_TMP_POLL, 1'b0, 8'h00, 4'h2,
			'{TMP[15:8], {TMP[7:2], TMP_TAIL}, 8'h00}, 1'b1, 4'h5};
		rows[7] = '{CMD_RD_USER, 1'b0, 8'h00, 4'h1,
			'{(USER_RST & ~USER_WMASK) | (8'h04 & USER_WMASK), 8'h00, 8'h00}, 1'b1, 4'h5};
		repeat (20) @(posedge core_clk_i);
		#1 rst_i = 1'b0;
		@(posedge core_clk_i) #1;
		for (int r = 0; r < 8; r++) xfer(r);
		// Second reset after the table rows must clear the heater and busy outputs while still asserted
		rst_i = 1'b1;
		repeat (40) @(posedge core_clk_i);
		#1 chk(heater_on_o, 1'b0);
		chk(heater_level_o, 4'h0);
		chk(dev_busy, 1'b0);
		rst_i = 1'b0;
		$display("test reset done");
		complete_run();
	end
endmodule : rh_temp_sensor_i2c_command_port_tb
